// *** lbh_hold.sv ***
// module: bus hold arbiter, read strobe and cycle status outputs
`timescale 1ns/100ps
// Functional notes
// [RQ1] hold ranks below refresh, above all else
// [RQ2] odd-odd dma word may delay grant
// [RQ3] grant deferred until locked sequence ends
// [RQ4] read strobe only on owned reads
// [RQ5] strobe only after bus floated
// [RQ6] strobe floats with pullup in hold/reset
// [RQ7] status lines give current cycle type
// [RQ8] s2 memory/io, s1 transmit/receive
// [RQ9] status float in hold, pullup in reset
// [RQ10] finish cycle, grant, float bus outputs
// [RQ11] drop grant when request drops
// [RQ12] drop grant early when refresh needed
// [RQ13] status code table per cycle type
// [RQ14] hold request synchronised by two flops
// [RQ15] idle status is all high
module lbh_hold
   import lbh_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // external master
   input wire logic i_hold_req,
   output logic o_bus_grant_out,
   // core side
   input wire lbh_req_t i_core_req,
   input wire logic i_refresh_req,
   output logic o_cycle_done,
   output logic o_refresh_busy,
   // read strobe pin (active low)
   output logic o_rd_n,
   output logic o_rd_n_oe,
   output logic o_rd_pu_en,
   // cycle status pins
   output logic o_cycle_status_2_n,
   output logic o_cycle_status_1_n,
   output logic o_cycle_status_0_n,
   output logic [2:0] o_cycle_status_oe,
   output logic o_cycle_status_pu_en,
   // muxed bus and other floated pins
   output logic o_muxed_addr_data_bus_oe,
   output logic o_bus_ctl_oe,
   output logic o_ctl_pu_en,
   output logic o_ale_pd_en
);
   // ---------------------------------------------------------------
   // state machine
   // ---------------------------------------------------------------
   typedef enum logic [5:0] {
      S_IDLE  = 6'h01,  // no cycle, bus owned
      S_ADDR  = 6'h02,  // address phase, bus driven
      S_TURN  = 6'h04,  // bus floated for read turnaround
      S_DATA  = 6'h08,  // data phase, strobe active on reads
      S_GRANT = 6'h10,  // bus given away
      S_REF   = 6'h20   // refresh cycle
   } lbh_state_t;

   lbh_state_t state_r, state_nxt;
   logic hold_s;            // synchronised hold request
   logic [1:0] cnt_r;       // phase counter
   logic [2:0] code_r;      // latched code of current cycle
   logic locked_r;          // inside a locked sequence
   logic in_reset_r;        // high until first edge after release

   function automatic logic is_read(input logic [2:0] c);
      is_read = (c == LBH_ST_IORD) || (c == LBH_ST_MEMRD) ||
                (c == LBH_ST_FETCH);
   endfunction

   // ---------------------------------------------------------------
   // hold request synchroniser
   // ---------------------------------------------------------------
   lbh_sync #(.STAGES(LBH_SYNC_STAGES)) u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_d(i_hold_req),
      .o_q(hold_s)
   );

   // reset marker keeps pins in the reset float state
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         in_reset_r <= 1'b1;
      end else begin
         in_reset_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic phase_end;
   always_comb begin
      state_nxt = state_r;
      phase_end = 1'b0;
      case (state_r)
         S_IDLE: begin
            // refresh first, then hold, then core cycles
            if (i_refresh_req) begin
               state_nxt = S_REF; // [RQ1]
            end else if (hold_s && !locked_r) begin
               state_nxt = S_GRANT; // [RQ1] [RQ3]
            end else if (i_core_req.valid) begin
               state_nxt = S_ADDR;
            end
         end
         S_ADDR: begin
            if (cnt_r == 2'(LBH_T1_CYC - 1)) begin
               // reads float the bus before the strobe
               state_nxt = is_read(code_r) ? S_TURN : S_DATA; // [RQ5]
            end
         end
         S_TURN: begin
            if (cnt_r == 2'(LBH_T2_CYC - 1)) begin
               state_nxt = S_DATA;
            end
         end
         S_DATA: begin
            if (cnt_r == 2'(LBH_T3_CYC - 1)) begin
               phase_end = 1'b1;
               // cycle in progress always completes first
               state_nxt = S_IDLE; // [RQ10] [RQ2]
            end
         end
         S_GRANT: begin
            if (!hold_s) begin
               state_nxt = S_IDLE; // [RQ11]
            end else if (i_refresh_req) begin
               state_nxt = S_IDLE; // [RQ12]
            end
         end
         S_REF: begin
            if (cnt_r == 2'(LBH_T3_CYC - 1)) begin
               state_nxt = S_IDLE;
            end
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= S_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // phase counter restarts on every state change
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_r <= 2'h0;
      end else if (state_nxt != state_r) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end

   // cycle code and lock latched when a cycle starts
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         code_r <= LBH_ST_IDLE;
         locked_r <= 1'b0;
      end else if (state_r == S_IDLE && state_nxt == S_ADDR) begin
         code_r <= i_core_req.code;
         locked_r <= i_core_req.locked; // [RQ3]
      end else if (phase_end && !i_core_req.locked) begin
         // lock ends when core stops flagging locked cycles
         locked_r <= 1'b0; // [RQ3]
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   logic granted;
   logic busy;
   assign granted = (state_r == S_GRANT);
   assign busy = (state_r == S_ADDR) || (state_r == S_TURN) ||
                 (state_r == S_DATA);

   // status and strobe values registered from next state
   logic [2:0] stat_r;
   logic rd_n_r;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stat_r <= LBH_ST_IDLE;
         rd_n_r <= 1'b1;
      end else begin
         if (state_nxt == S_ADDR || state_nxt == S_TURN ||
             state_nxt == S_DATA) begin
            stat_r <= (state_r == S_IDLE) ? i_core_req.code
                                          : code_r; // [RQ7] [RQ13]
         end else begin
            stat_r <= LBH_ST_IDLE; // [RQ15]
         end
         // strobe low only in data phase of an owned read
         rd_n_r <= !(state_nxt == S_DATA && is_read(code_r)); // [RQ4]
      end
   end

   assign o_bus_grant_out = granted; // [RQ10]
   assign o_cycle_done = phase_end;
   assign o_refresh_busy = (state_r == S_REF);

   // strobe floats in hold and reset, pullup holds it high
   assign o_rd_n = rd_n_r;
   assign o_rd_n_oe = !granted && !in_reset_r; // [RQ6]
   assign o_rd_pu_en = granted || in_reset_r; // [RQ6]

   // s2 is memory/io, s1 is transmit/receive on their own
   assign o_cycle_status_2_n = stat_r[2]; // [RQ8]
   assign o_cycle_status_1_n = stat_r[1]; // [RQ8]
   assign o_cycle_status_0_n = stat_r[0];
   assign o_cycle_status_oe = (granted || in_reset_r) ? 3'h0
                                                       : 3'h7; // [RQ9]
   // pullups on status only in reset, not in hold
   assign o_cycle_status_pu_en = in_reset_r; // [RQ9]

   // bus floated in hold and during read turnaround
   assign o_muxed_addr_data_bus_oe = !granted && !in_reset_r &&
      !(busy && is_read(code_r) && state_r != S_ADDR); // [RQ5] [RQ10]
   assign o_bus_ctl_oe = !granted && !in_reset_r; // [RQ10]
   assign o_ctl_pu_en = granted || in_reset_r; // [RQ10]
   assign o_ale_pd_en = granted || in_reset_r; // [RQ10]
endmodule

// *** lbh_pkg.sv ***
// package: shared constants and types for the local bus hold block
package lbh_pkg;
   // ---------------------------------------------------------------
   // bus cycle status codes, s2 s1 s0 (active-low lines)
   // ---------------------------------------------------------------
   localparam logic [2:0] LBH_ST_RSVD = 3'h0;
   localparam logic [2:0] LBH_ST_IORD = 3'h1;
   localparam logic [2:0] LBH_ST_IOWR = 3'h2;
   localparam logic [2:0] LBH_ST_HALT = 3'h3;
   localparam logic [2:0] LBH_ST_FETCH = 3'h4;
   localparam logic [2:0] LBH_ST_MEMRD = 3'h5;
   localparam logic [2:0] LBH_ST_MEMWR = 3'h6;
   localparam logic [2:0] LBH_ST_IDLE = 3'h7;
   // ---------------------------------------------------------------
   // timing figures
   // ---------------------------------------------------------------
   localparam int LBH_CLK_NS = 50;
   localparam int LBH_T1_CYC = 1;  // address phase length
   localparam int LBH_T2_CYC = 1;  // turnaround before strobe
   localparam int LBH_T3_CYC = 2;  // data phase length
   localparam int LBH_SYNC_STAGES = 2;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       valid;  // core asks for a bus cycle
      logic [2:0] code;   // cycle type as a status code
      logic       locked; // part of a locked sequence
   } lbh_req_t;
   typedef struct packed {
      logic [2:0] o;   // driven value
      logic [2:0] oe;  // high while driven
      logic       pu;  // pullup enable
   } lbh_stat_pin_t;
endpackage

// *** lbh_sync.sv ***
// module: two-stage synchroniser for the hold request
`timescale 1ns/100ps
module lbh_sync
   import lbh_pkg::*;
#(
   parameter int STAGES = LBH_SYNC_STAGES
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // async level in, synced level out
   input wire logic i_d,
   output logic o_q
);
   // ---------------------------------------------------------------
   // shift chain
   // ---------------------------------------------------------------
   logic [STAGES-1:0] chain_r; // only the last bit is read outside
   // first stage feeds only the next stage, never logic
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         chain_r <= '0;
      end else begin
         chain_r <= {chain_r[STAGES-2:0], i_d}; // [RQ14]
      end
   end
   assign o_q = chain_r[STAGES-1];
endmodule

// *** lbh_hold_assertions.sv ***
// checker: grant, strobe and status relations at the hold block pins
`timescale 1ns/100ps
module lbh_hold_chk
   import lbh_pkg::*;
(
   // clock, reset, request
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_hold_req,
   // pins watched
   input wire logic o_bus_grant_out,
   input wire logic o_cycle_done,
   input wire logic o_rd_n,
   input wire logic o_rd_n_oe,
   input wire logic o_rd_pu_en,
   input wire logic o_cycle_status_2_n,
   input wire logic o_cycle_status_1_n,
   input wire logic o_cycle_status_0_n,
   input wire logic [2:0] o_cycle_status_oe,
   input wire logic o_muxed_addr_data_bus_oe,
   input wire logic o_bus_ctl_oe,
   input wire logic o_ctl_pu_en,
   input wire logic o_ale_pd_en
);
   // status lines as one code, s2 first
   logic [2:0] st;
   assign st = {o_cycle_status_2_n, o_cycle_status_1_n, o_cycle_status_0_n};
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // ---------------------------------------------------------------
   // strobe, float, grant and status timing
   // ---------------------------------------------------------------
   AST_RD_OWN: assert property (
      !o_rd_n |-> o_rd_n_oe && !o_bus_grant_out && !o_cycle_status_1_n)
      else $error("read strobe outside an owned read");
   AST_RD_TURN: assert property (
      !o_rd_n |-> !o_muxed_addr_data_bus_oe)
      else $error("read strobe while bus still driven");
   AST_RD_FLT: assert property (
      o_bus_grant_out |-> !o_rd_n_oe && o_rd_pu_en)
      else $error("read strobe not floated in hold");
   AST_ST_FLT: assert property (
      o_bus_grant_out |-> o_cycle_status_oe == 3'h0)
      else $error("status driven in hold");
   AST_BUS_FLT: assert property (
      o_bus_grant_out |-> !o_muxed_addr_data_bus_oe && !o_bus_ctl_oe
      && o_ctl_pu_en && o_ale_pd_en)
      else $error("bus pins not floated in hold");
   AST_GNT_SYNC: assert property (
      $rose(o_bus_grant_out) |-> $past(i_hold_req, 3) && $past(i_hold_req))
      else $error("grant ahead of synchronised request");
   AST_GNT_DROP: assert property (
      $fell(i_hold_req) |-> ##[1:4] !o_bus_grant_out)
      else $error("grant kept after request dropped");
   AST_DONE_IDLE: assert property (
      o_cycle_done |=> st == LBH_ST_IDLE)
      else $error("status not idle after cycle");
endmodule
bind lbh_hold lbh_hold_chk u_chk (
   .i_clk(i_clk),
   .i_rst_n(i_rst_n),
   .i_hold_req(i_hold_req),
   .o_bus_grant_out(o_bus_grant_out),
   .o_cycle_done(o_cycle_done),
   .o_rd_n(o_rd_n),
   .o_rd_n_oe(o_rd_n_oe),
   .o_rd_pu_en(o_rd_pu_en),
   .o_cycle_status_2_n(o_cycle_status_2_n),
   .o_cycle_status_1_n(o_cycle_status_1_n),
   .o_cycle_status_0_n(o_cycle_status_0_n),
   .o_cycle_status_oe(o_cycle_status_oe),
   .o_muxed_addr_data_bus_oe(o_muxed_addr_data_bus_oe),
   .o_bus_ctl_oe(o_bus_ctl_oe),
   .o_ctl_pu_en(o_ctl_pu_en),
   .o_ale_pd_en(o_ale_pd_en)
);

// *** lbh_ext_master.sv ***
// model: external master that borrows the local bus
`timescale 1ns/100ps
module lbh_ext_master (
   // clock and bench command
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic [3:0] i_len,
   // hold handshake
   input wire logic i_grant,
   output logic o_hold_req
);
   logic [3:0] left; // granted cycles still wanted
   logic had; // grant seen in this tenure
   initial o_hold_req = 1'b0;
   // acts off the falling edge, like the bench
   always @(negedge i_clk) begin
      if (i_go && !o_hold_req) begin
         o_hold_req <= 1'b1;
         left <= i_len;
         had <= 1'b0;
      end else if (o_hold_req && i_grant) begin
         had <= 1'b1;
         left <= left - 4'h1;
         // done with the bus: give it back
         if (left == 4'h0) begin
            o_hold_req <= 1'b0;
         end
      end else if (o_hold_req && had) begin
         o_hold_req <= 1'b0;
      end
   end
endmodule

// *** tb_top.sv ***
// bench: core cycles, hold tenure, lock and refresh on the hold block
`timescale 1ns/100ps
module tb_top;
   import lbh_pkg::*;
   logic i_clk, i_rst_n, i_refresh_req, go, hold, gnt, done, busy;
   logic rdn, rdoe, rdpu, s2, s1, s0, spu, boe, coe, cpu, apd;
   logic [2:0] soe;
   logic [3:0] len;
   lbh_req_t req;
   int n_mismatch = 0;
   int num_checks = 0;
   wire rd_w = rdoe ? rdn : 1'b1; // pullup once released
   lbh_hold uut (.i_clk, .i_rst_n, .i_hold_req(hold), .o_bus_grant_out(gnt),
      .i_core_req(req), .i_refresh_req, .o_cycle_done(done),
      .o_refresh_busy(busy), .o_rd_n(rdn), .o_rd_n_oe(rdoe),
      .o_rd_pu_en(rdpu), .o_cycle_status_2_n(s2), .o_cycle_status_1_n(s1),
      .o_cycle_status_0_n(s0), .o_cycle_status_oe(soe),
      .o_cycle_status_pu_en(spu), .o_muxed_addr_data_bus_oe(boe),
      .o_bus_ctl_oe(coe), .o_ctl_pu_en(cpu), .o_ale_pd_en(apd));
   lbh_ext_master ext (.i_clk, .i_go(go), .i_len(len), .i_grant(gnt),
      .o_hold_req(hold));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // bounded wait for the grant level
   task automatic w_gnt(input logic v);
      for (int k = 0; k < 12 && gnt !== v; k++) tick(1);
      chk(8'(gnt), 8'(v));
   endtask
   // one core cycle: code shown, strobe on reads only, idle after
   task automatic t_cyc(input logic [2:0] c);
      logic rd;
      rd = 1'b0;
      req <= '{1'b1, c, 1'b0};
      tick(1);
      req <= '0;
      tick(1);
      chk(8'({s2, s1, s0}), 8'(c));
      for (int k = 0; k < 8 && done !== 1'b1; k++) begin
         tick(1);
         rd = rd | (rd_w === 1'b0);
      end
      chk(8'({rd, done}), 8'({c inside {3'h1, 3'h4, 3'h5}, 1'b1}));
      tick(1);
      chk(8'({s2, s1, s0}), 8'(LBH_ST_IDLE));
   endtask
   // a tenure: pins float while granted, status back after
   task automatic t_hold;
      len <= 4'h3;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      w_gnt(1'b1);
      chk({soe, boe, coe, cpu, apd, rdoe}, 8'h06);
      // status floats without pullup while held away
      chk(8'(spu), 8'h00);
      w_gnt(1'b0);
      tick(2);
      chk(8'(soe), 8'h07);
   endtask
   // hold waits out a two-cycle locked sequence
   task automatic t_lock;
      int d;
      d = 0;
      len <= 4'h1;
      req <= '{1'b1, LBH_ST_MEMRD, 1'b1};
      go <= 1'b1;
      for (int k = 0; k < 30 && d < 2; k++) begin
         tick(1);
         go <= 1'b0;
         chk(8'(gnt), 8'h00);
         d += int'(done === 1'b1);
      end
      req <= '0;
      w_gnt(1'b1);
      w_gnt(1'b0);
   endtask
   // refresh need pulls the grant back while hold is still up
   task automatic t_refr;
      len <= 4'hF;
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      w_gnt(1'b1);
      i_refresh_req <= 1'b1;
      for (int k = 0; k < 8 && busy !== 1'b1; k++) tick(1);
      i_refresh_req <= 1'b0;
      chk(8'({busy, gnt}), 8'h02);
      tick(2);
      chk(8'(hold), 8'h00);
   endtask
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   // watchdog at 2000 cycles, well past the fewer than a hundred cycles of the run
   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end
   initial begin
      i_rst_n = 1'b0;
      i_refresh_req = 1'b0;
      go = 1'b0;
      len = 4'h0;
      req = '0;
      tick(4);
      chk({gnt, soe, spu, rdoe, rdpu, rd_w}, 8'h0B);
      chk(8'({s2, s1, s0}), 8'(LBH_ST_IDLE));
      i_rst_n <= 1'b1;
      tick(2);
      for (int c = 1; c < 7; c++) t_cyc(3'(c));
      t_hold();
      t_lock();
      t_refr();
      conclude();
   end
endmodule
